//--- inc/chp_cfg.svh
`ifndef CHP_CFG_SVH
`define CHP_CFG_SVH
// sample and internal widths
`define CHP_DW 24
`define CHP_AW 32
// register byte offsets
`define CHP_CFG0_OFS 12'h000
`define CHP_CFG2_OFS 12'h004
`define CHP_DICO_OFS 12'h008
`define CHP_IGAIN_OFS 12'h00c
`define CHP_REGION_OFS 12'h010
// coefficient memory window 0x080..0x0fc
`define CHP_MEM_SEL 5'h01
`define CHP_MEM_WORDS 5'h14
`define CHP_GAIN_BASE 5'h00
`define CHP_PHC_BASE 5'h05
`define CHP_LO_BASE 5'h0a
`define CHP_HI_BASE 5'h0f
// reset values
`define CHP_CFG0_RST 4'h0
`define CHP_CORNER_RST 3'h6
// region limits
`define CHP_REGION_UP_MAX 3'h3
`define CHP_REGION_DN_MIN 3'h1
`define CHP_REGION_MAX 3'h4
// arithmetic shifts
`define CHP_HPF_SH_BASE 6'h04
`define CHP_COEF_FRAC 6'h1b
`define CHP_INT_FRAC 6'h1f
`define CHP_INT_SH 6'h04
// bus read latency in wait cycles
`define CHP_RD_WAIT 2'h2
`endif

//--- inc/chp_pkg.sv
`include "chp_cfg.svh"
package chp_pkg;
  // control bits of config_reg_zero, bit 3 down to bit 0
  typedef struct packed {
    logic multipoint_enable;
    logic neutral_integrate_en;
    logic phase_current_integrate_en;
    logic hpf_disable_bit;
  } chp_cfg0_type;

  // one set of samples: phase current, voltage, neutral current
  typedef struct packed {
    logic signed [`CHP_DW-1:0] i;
    logic signed [`CHP_DW-1:0] v;
    logic signed [`CHP_DW-1:0] n;
  } chp_samp_type;

  typedef enum logic [2:0] {
    S_IDLE, S_RDHI, S_RDLO, S_DEC, S_LDG, S_LDP, S_DONE
  } chp_mt_state_type;
endpackage : chp_pkg

//--- hdl/chp_coef_mem.sv
`timescale 1ns/1ps
module chp_coef_mem #(
  parameter int DEPTH = 32,
  parameter int ABITS = 5
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic we,
  input wire logic [ABITS-1:0] waddr,
  input wire logic [31:0] wdata,
  input wire logic [ABITS-1:0] a_addr,
  output logic [31:0] a_rdata,
  input wire logic [ABITS-1:0] b_addr,
  output logic [31:0] b_rdata
);
  logic [31:0] mem [DEPTH];

  initial begin
    if (DEPTH > (1 << ABITS) || DEPTH < 20) begin
      $error("chp_coef_mem: depth does not fit address width");
    end
  end

  // storage, cleared at reset so coefficients start at zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int k = 0; k < DEPTH; k++) begin
        mem[k] <= 32'h0000_0000;
      end
    end else if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // registered read ports: bus side and region engine side
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_rdata <= 32'h0000_0000;
      b_rdata <= 32'h0000_0000;
    end else begin
      a_rdata <= mem[a_addr];
      b_rdata <= mem[b_addr];
    end
  end
endmodule : chp_coef_mem

//--- hdl/chp_channel.sv
// How it works
// - hpf on after reset; disable bit 0 bypasses it on current, voltage and neutral
// - 3-bit corner code halves corner per step; code 6 after reset
// - corner code sets only the hpf shift, 4 plus code; channel gain is not changed
// - integrator gives -20 dB/decade and about -90 degrees phase
// - one bit integrates phase current, another bit the neutral current
// - voltage always delayed by exactly one dsp sample
// - current delayed by filter with signed phase coefficient times 2^-27
// - phase resolution near 0.001 degree, range -15 to one sample
// - base current gain always applied
// - multipoint off at reset; enabled adds region gain and phase pair
// - region steps up above high threshold, down below low threshold
// - selected region coefficients applied; region index readable
// - multipoint off: next engine run (rms or coefficient write) loads no extra gain, region zero phase coefficient
//
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "chp_cfg.svh"
module chp_channel #(
  parameter int MEM_DEPTH = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic samp_valid,
  input wire chp_pkg::chp_samp_type samp_in,
  input wire logic rms_valid,
  input wire logic signed [31:0] rms_in,
  output logic pcf_valid,
  output chp_pkg::chp_samp_type pcf_out
);
  localparam int DW = `CHP_DW;
  localparam int AW = `CHP_AW;
  localparam logic signed [AW-1:0] MAXV =
    {{(AW-DW+1){1'b0}}, {(DW-1){1'b1}}};
  localparam logic signed [AW-1:0] MINV = ~MAXV;
  // local names for the engine states
  localparam chp_pkg::chp_mt_state_type S_IDLE = chp_pkg::S_IDLE;
  localparam chp_pkg::chp_mt_state_type S_RDHI = chp_pkg::S_RDHI;
  localparam chp_pkg::chp_mt_state_type S_RDLO = chp_pkg::S_RDLO;
  localparam chp_pkg::chp_mt_state_type S_DEC = chp_pkg::S_DEC;
  localparam chp_pkg::chp_mt_state_type S_LDG = chp_pkg::S_LDG;
  localparam chp_pkg::chp_mt_state_type S_LDP = chp_pkg::S_LDP;
  localparam chp_pkg::chp_mt_state_type S_DONE = chp_pkg::S_DONE;

  chp_pkg::chp_cfg0_type cfg0_r;
  logic [2:0] corner_r;
  logic signed [31:0] dico_r, igain_r, mtg_r, phc_r, hi_r, rms_r;
  logic [2:0] region_r;
  chp_pkg::chp_mt_state_type st_r;
  logic pend_r, acc, wr_pend_r, wr_en, mem_we, start;
  logic [11:0] wr_addr_r, rd_addr_r;
  logic [1:0] rd_cnt_r;
  logic [31:0] a_rdata, b_rdata, rd_val;
  logic [4:0] b_addr;
  logic signed [AW-1:0] i_xp_r, i_hy_r, i_iy_r, i_pp_r;
  logic signed [AW-1:0] v_xp_r, v_hy_r, v_dly_r, n_xp_r, n_hy_r, n_iy_r;
  logic signed [AW-1:0] i_x, i_hf, i_h, i_it, i_g, i_p, i_b, i_m;
  logic signed [AW-1:0] v_x, v_hf, v_h, n_x, n_hf, n_h, n_it, n_g;
  logic [5:0] hpf_sh;

  function automatic logic signed [AW-1:0] ext(
    input logic signed [DW-1:0] x);
    return {{(AW-DW){x[DW-1]}}, x};
  endfunction : ext

  function automatic logic signed [DW-1:0] sat(
    input logic signed [AW-1:0] a);
    logic signed [AW-1:0] t;
    t = (a > MAXV) ? MAXV : ((a < MINV) ? MINV : a);
    return t[DW-1:0];
  endfunction : sat

  // signed product scaled down by a power of two
  function automatic logic signed [AW-1:0] mul_shift(
    input logic signed [AW-1:0] a, input logic signed [31:0] c,
    input logic [5:0] sh);
    logic signed [63:0] p;
    p = 64'(a) * 64'(c);
    p = p >>> sh;
    return p[AW-1:0];
  endfunction : mul_shift

  // first-order dc blocker, pole 1 - 2^-sh
  function automatic logic signed [AW-1:0] hpf_step(
    input logic signed [AW-1:0] x, input logic signed [AW-1:0] xp,
    input logic signed [AW-1:0] yp, input logic [5:0] sh);
    return x - xp + yp - (yp >>> sh);
  endfunction : hpf_step

  // leaky accumulator, leak set by the integrator coefficient
  function automatic logic signed [AW-1:0] int_step(
    input logic signed [AW-1:0] x, input logic signed [AW-1:0] yp,
    input logic signed [31:0] c);
    return yp + (x >>> `CHP_INT_SH) + mul_shift(yp, c, `CHP_INT_FRAC);
  endfunction : int_step

  // ---------------- bus slave ----------------
  assign acc = hsel && htrans[1] && hready;
  assign wr_en = wr_pend_r && hready;
  assign mem_we = wr_en && (wr_addr_r[11:7] == `CHP_MEM_SEL);

  // address phase capture and write data phase tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
      rd_addr_r <= 12'h000;
    end else if (hready) begin
      wr_pend_r <= acc && hwrite;
      if (acc && hwrite) begin
        wr_addr_r <= haddr[11:0];
      end
      if (acc && !hwrite) begin
        rd_addr_r <= haddr[11:0];
      end
    end
  end

  // every read stalls two cycles, then data from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_cnt_r <= 2'h0;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (acc && !hwrite) begin
        rd_cnt_r <= `CHP_RD_WAIT;
        hreadyout <= 1'b0;
      end else if (rd_cnt_r != 2'h0) begin
        rd_cnt_r <= rd_cnt_r - 2'h1;
        if (rd_cnt_r == 2'h1) begin
          hreadyout <= 1'b1;
          hrdata <= rd_val;
        end
      end
    end
  end

  // read decode; unmapped words read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    case ({rd_addr_r[11:2], 2'h0})
      `CHP_CFG0_OFS: rd_val = {28'h0, cfg0_r};
      `CHP_CFG2_OFS: rd_val = {29'h0, corner_r};
      `CHP_DICO_OFS: rd_val = dico_r;
      `CHP_IGAIN_OFS: rd_val = igain_r;
      `CHP_REGION_OFS: rd_val = {29'h0, region_r};
      default: begin
        if (rd_addr_r[11:7] == `CHP_MEM_SEL &&
            rd_addr_r[6:2] < `CHP_MEM_WORDS) begin
          rd_val = a_rdata;
        end
      end
    endcase
  end

  // control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg0_r <= `CHP_CFG0_RST;
      corner_r <= `CHP_CORNER_RST;
      dico_r <= 32'h0000_0000;
      igain_r <= 32'h0000_0000;
    end else if (wr_en) begin
      case (wr_addr_r)
        `CHP_CFG0_OFS: cfg0_r <= hwdata[3:0];
        `CHP_CFG2_OFS: corner_r <= hwdata[2:0];
        `CHP_DICO_OFS: dico_r <= hwdata;
        `CHP_IGAIN_OFS: igain_r <= hwdata;
        default: ;
      endcase
    end
  end

  chp_coef_mem #(.DEPTH(MEM_DEPTH), .ABITS(5)) chp_coef_mem_inst (
    .hclk(hclk),
    .hresetn(hresetn),
    .we(mem_we),
    .waddr(wr_addr_r[6:2]),
    .wdata(hwdata),
    .a_addr(rd_addr_r[6:2]),
    .a_rdata(a_rdata),
    .b_addr(b_addr),
    .b_rdata(b_rdata)
  );

  // ---------------- region engine ----------------
  assign start = (st_r == S_IDLE) && (rms_valid || pend_r);

  // rerun after rms arriving mid-run or a coefficient write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_r <= 1'b0;
      rms_r <= 32'h0000_0000;
    end else begin
      pend_r <= mem_we || (rms_valid && st_r != S_IDLE) ||
                (pend_r && !start);
      if (rms_valid) begin
        rms_r <= rms_in;
      end
    end
  end

  // memory address for each engine step
  always_comb begin
    case (st_r)
      S_RDHI: b_addr = `CHP_HI_BASE + {2'h0, region_r};
      S_RDLO: b_addr = `CHP_LO_BASE + {2'h0, region_r};
      S_LDG: b_addr = `CHP_GAIN_BASE + {2'h0, region_r};
      S_LDP: b_addr = `CHP_PHC_BASE + {2'h0, region_r};
      default: b_addr = `CHP_GAIN_BASE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= S_IDLE;
    end else begin
      case (st_r)
        S_IDLE: if (start) st_r <= cfg0_r.multipoint_enable ? S_RDHI : S_LDG;
        S_RDHI: st_r <= S_RDLO;
        S_RDLO: st_r <= S_DEC;
        S_DEC: st_r <= S_LDG;
        S_LDG: st_r <= S_LDP;
        S_LDP: st_r <= S_DONE;
        S_DONE: st_r <= S_IDLE;
        default: st_r <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      region_r <= 3'h0;
      hi_r <= 32'h0000_0000;
    end else if (!cfg0_r.multipoint_enable) begin
      region_r <= 3'h0;
    end else begin
      if (st_r == S_RDLO) begin
        hi_r <= b_rdata;
      end
      if (st_r == S_DEC) begin
        if (rms_r > hi_r) begin
          if (region_r <= `CHP_REGION_UP_MAX) region_r <= region_r + 3'h1;
        end else if (rms_r < $signed(b_rdata)) begin
          if (region_r >= `CHP_REGION_DN_MIN) region_r <= region_r - 3'h1;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mtg_r <= 32'h0000_0000;
      phc_r <= 32'h0000_0000;
    end else begin
      if (st_r == S_LDP) begin
        mtg_r <= cfg0_r.multipoint_enable ? b_rdata : 32'h0000_0000;
      end
      if (st_r == S_DONE) begin
        phc_r <= b_rdata;
      end
    end
  end

  // ---------------- sample datapath ----------------
  // corner shift from code
  assign hpf_sh = `CHP_HPF_SH_BASE + {3'h0, corner_r};

  // one combinational pass per sample
  always_comb begin
    i_x = ext(samp_in.i);
    v_x = ext(samp_in.v);
    n_x = ext(samp_in.n);
    i_hf = hpf_step(i_x, i_xp_r, i_hy_r, hpf_sh);
    v_hf = hpf_step(v_x, v_xp_r, v_hy_r, hpf_sh);
    n_hf = hpf_step(n_x, n_xp_r, n_hy_r, hpf_sh);
    i_h = cfg0_r.hpf_disable_bit ? i_x : i_hf;
    v_h = cfg0_r.hpf_disable_bit ? v_x : v_hf;
    n_h = cfg0_r.hpf_disable_bit ? n_x : n_hf;
    i_it = int_step(i_h, i_iy_r, dico_r);
    n_it = int_step(n_h, n_iy_r, dico_r);
    i_g = cfg0_r.phase_current_integrate_en ? i_it : i_h;
    n_g = cfg0_r.neutral_integrate_en ? n_it : n_h;
    i_p = i_pp_r + mul_shift(i_g, phc_r, `CHP_COEF_FRAC);
    i_b = i_p + mul_shift(i_p, igain_r, `CHP_COEF_FRAC);
    i_m = i_b + mul_shift(i_b, mtg_r, `CHP_COEF_FRAC);
  end

  // filter state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      i_xp_r <= '0; i_hy_r <= '0; i_iy_r <= '0; i_pp_r <= '0;
      v_xp_r <= '0; v_hy_r <= '0; v_dly_r <= '0;
      n_xp_r <= '0; n_hy_r <= '0; n_iy_r <= '0;
    end else if (samp_valid) begin
      i_xp_r <= i_x; i_hy_r <= i_hf; i_pp_r <= i_g;
      v_xp_r <= v_x; v_hy_r <= v_hf;
      n_xp_r <= n_x; n_hy_r <= n_hf;
      i_iy_r <= cfg0_r.phase_current_integrate_en ? i_it : '0;
      n_iy_r <= cfg0_r.neutral_integrate_en ? n_it : '0;
      v_dly_r <= v_h;
    end
  end

  // outputs, one cycle after each input sample
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pcf_valid <= 1'b0;
      pcf_out <= '0;
    end else begin
      pcf_valid <= samp_valid;
      if (samp_valid) begin
        pcf_out.i <= sat(i_m);
        pcf_out.v <= sat(v_dly_r);
        pcf_out.n <= sat(n_g);
      end
    end
  end

  // ---------------- checks ----------------
  logic seen_r, byp_r, nbyp_r;
  logic signed [DW-1:0] vc_r, vp_r, nc_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen_r <= 1'b0; byp_r <= 1'b0; nbyp_r <= 1'b0;
      vc_r <= '0; vp_r <= '0; nc_r <= '0;
    end else begin
      seen_r <= 1'b1;
      if (samp_valid) begin
        vc_r <= samp_in.v; vp_r <= vc_r; nc_r <= samp_in.n;
        byp_r <= cfg0_r.hpf_disable_bit && byp_r;
        nbyp_r <= cfg0_r.hpf_disable_bit && !cfg0_r.neutral_integrate_en;
        if (!cfg0_r.hpf_disable_bit) byp_r <= 1'b0;
        else if (!byp_r) byp_r <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence eval_s;
    st_r == S_RDHI ##1 st_r == S_RDLO ##1 st_r == S_DEC;
  endsequence
  sequence load_s;
    st_r == S_LDG ##1 st_r == S_LDP ##1 st_r == S_DONE ##1 st_r == S_IDLE;
  endsequence

  hpf_reset_on_a: assert property (
    !seen_r |-> !cfg0_r.hpf_disable_bit && !cfg0_r.multipoint_enable)
    else $error("hpf or multipoint not in reset state");
  corner_default_a: assert property (
    !seen_r |-> corner_r == 3'h6 && hpf_sh == 6'h0a)
    else $error("corner code not default after reset");
  volt_delay_a: assert property (
    pcf_valid && byp_r && $past(byp_r) |-> pcf_out.v == vp_r)
    else $error("voltage not delayed by one sample");
  neutral_plain_a: assert property (
    pcf_valid && nbyp_r |-> pcf_out.n == nc_r)
    else $error("neutral path altered while bypassed");
  region_up_a: assert property (
    st_r == S_DEC && cfg0_r.multipoint_enable && rms_r > hi_r &&
    region_r <= 3'h3 ##1 cfg0_r.multipoint_enable
    |-> region_r == $past(region_r) + 3'h1)
    else $error("region did not step up");
  region_bound_a: assert property (
    region_r <= 3'h4)
    else $error("region index out of range");
  mt_eval_a: assert property (
    start && cfg0_r.multipoint_enable |=> eval_s ##1 load_s)
    else $error("region evaluation sequence broken");
  mt_off_gain_a: assert property (
    st_r == S_LDP && !cfg0_r.multipoint_enable |=> mtg_r == 32'h0
    ##1 phc_r == $past(b_rdata))
    else $error("extra gain applied with multipoint off");
  mt_off_region_a: assert property (
    !cfg0_r.multipoint_enable [*2] |-> region_r == 3'h0)
    else $error("region not zero with multipoint off");
endmodule : chp_channel

//--- verification/chp_src_model.sv
`timescale 1ns/1ps
// decimator and rms source feeding the block
module chp_src_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic req,
  input wire chp_pkg::chp_samp_type req_samp,
  input wire logic rms_req,
  input wire logic signed [31:0] rms_req_val,
  output logic samp_valid,
  output chp_pkg::chp_samp_type samp_in,
  output logic rms_valid,
  output logic signed [31:0] rms_in
);
  // one-cycle pulses; idle data lines flip every cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      samp_valid <= 1'b0;
      samp_in <= '0;
      rms_valid <= 1'b0;
      rms_in <= '0;
    end else begin
      samp_valid <= req;
      samp_in <= req ? req_samp : ~samp_in;
      rms_valid <= rms_req;
      rms_in <= rms_req ? rms_req_val : ~rms_in;
    end
  end
endmodule : chp_src_model

//--- verification/channel_hpf_integrator_phase_cal_test.sv
`timescale 1ns/1ps
`include "chp_cfg.svh"
module channel_hpf_integrator_phase_cal_test;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rng, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic req, rms_req, samp_valid, rms_valid, pcf_valid;
  logic signed [31:0] rms_req_val, rms_in;
  chp_pkg::chp_samp_type req_samp, samp_in, pcf_out, last_out, s1, s2, o2;
  logic [71:0] exp_q[$], msk_q[$], oe, om;
  logic signed [23:0] drop [0:8];
  int error_cnt, samples_checked;
  int rv [0:10] = '{150, 150, 500, 500, 500, 500, 10, 10, 10, 10, 10};
  int rx [0:10] = '{1, 1, 2, 3, 4, 4, 3, 2, 1, 0, 0};
  int lo [0:4] = '{20, 50, 150, 250, 350};
  int hi [0:4] = '{100, 200, 300, 400, 450};

  chp_channel chp_channel_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .samp_valid(samp_valid), .samp_in(samp_in),
    .rms_valid(rms_valid), .rms_in(rms_in), .pcf_valid(pcf_valid),
    .pcf_out(pcf_out)
  );
  chp_src_model chp_src_model_inst (
    .hclk(hclk), .hresetn(hresetn), .req(req), .req_samp(req_samp),
    .rms_req(rms_req), .rms_req_val(rms_req_val),
    .samp_valid(samp_valid), .samp_in(samp_in),
    .rms_valid(rms_valid), .rms_in(rms_in)
  );

  // clock
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // compare and count
  task automatic chk(input logic [71:0] got, input logic [71:0] ex);
    samples_checked++;
    if (got !== ex) begin
      error_cnt++;
      $display("unexpected at %0t got %h exp %h", $time, got, ex);
    end
  endtask : chk

  // verdict and end of run
  task results;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  // xorshift source, small even values
  function automatic logic signed [23:0] xr();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return {{11{rng[12]}}, rng[12:1], 1'b0};
  endfunction : xr

  function automatic logic [11:0] ma(input int k);
    return 12'h080 + 12'(4 * k);
  endfunction : ma

  // output watcher takes oldest note
  always @(posedge hclk) begin
    if (pcf_valid === 1'b1) begin
      last_out = pcf_out;
      if (exp_q.size() == 0) begin
        chk(pcf_out, ~pcf_out);
      end else begin
        oe = exp_q.pop_front();
        om = msk_q.pop_front();
        chk(pcf_out & om, oe & om);
      end
    end
  end

  // ahb-lite single word transfer
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 40);
    if (k >= 40) begin
      error_cnt++;
      results();
    end
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 80);
    rd = hrdata;
    chk(72'(hresp), 72'h0);
    if (k >= 80) begin
      error_cnt++;
      results();
    end
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    chk(72'(rd), 72'(x));
  endtask : rdc

  task automatic do_reset;
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask : do_reset

  // one sample request, expected result noted
  task automatic send(input logic [71:0] s, input logic [71:0] ex,
                      input logic [71:0] mk);
    exp_q.push_back(ex);
    msk_q.push_back(mk);
    req <= 1'b1;
    req_samp <= s;
    @(posedge hclk);
    req <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask : send

  // first sample primes delays, second checked with gain g
  task automatic pair(input logic signed [23:0] g, input logic ph);
    s1 = {xr(), xr(), xr()};
    s2 = {xr(), xr(), xr()};
    send(s1, 72'h0, 72'h0);
    send(s2, {24'(g * s1.i + (ph ? (g * s2.i) >>> 1 : 0)), s1.v, s2.n},
         {72{1'b1}});
  endtask : pair

  task automatic dc3(input logic [71:0] mk);
    send(s1, 72'h0, 72'h0);
    send(s1, s1, mk);
    o2 = last_out;
    send(s1, s1, mk);
  endtask : dc3

  // hang guard
  initial begin
    repeat (90000) @(posedge hclk);
    error_cnt++;
    results();
  end

  // main sequence
  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, req, rms_req} = 4'h0;
    {haddr, hwdata, rms_req_val} = 96'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    req_samp = '0;
    error_cnt = 0;
    samples_checked = 0;
    rng = 32'h4f65f23c;
    do_reset();
    rdc(`CHP_CFG2_OFS, 32'h6);
    rdc(`CHP_CFG0_OFS, 32'h0);
    rdc(`CHP_IGAIN_OFS, 32'h0);
    rdc(12'h020, 32'h0);
    rdc(ma(25), 32'h0);
    wr(`CHP_REGION_OFS, 32'h7);
    rdc(`CHP_REGION_OFS, 32'h0);
    wr(`CHP_DICO_OFS, 32'hffffe000);
    rdc(`CHP_DICO_OFS, 32'hffffe000);
    // corner sweep on a dc step, last pass keeps reset code
    for (int k = 0; k < 9; k++) begin
      do_reset();
      if (k < 8)
        wr(`CHP_CFG2_OFS, 32'(k));
      s1 = {48'h0, 24'h400000};
      send(s1, 72'h0, 72'h0);
      send(s1, 72'h0, 72'h0);
      drop[k] = 24'h400000 - last_out.n;
    end
    for (int k = 1; k < 8; k++)
      chk(72'(drop[k - 1] > drop[k]), 72'h1);
    chk(72'(drop[8]), 72'(drop[6]));
    chk(72'(drop[7] > 0), 72'h1);
    // voltage and current one sample late, hpf bypassed
    do_reset();
    wr(`CHP_CFG0_OFS, 32'h1);
    s1 = {xr(), xr(), xr()};
    send(s1, 72'h0, 72'h0);
    for (int k = 0; k < 20; k++) begin
      s2 = {xr(), xr(), xr()};
      send(s2, {s1.i, s1.v, s2.n}, {72{1'b1}});
      s1 = s2;
    end
    wr(`CHP_IGAIN_OFS, 32'h08000000);
    pair(24'sd2, 1'b0);
    wr(ma(`CHP_PHC_BASE), 32'h04000000);
    repeat (12) @(posedge hclk);
    pair(24'sd2, 1'b1);
    // integrator bits act on their own channel
    do_reset();
    wr(`CHP_DICO_OFS, 32'hffffe000);
    wr(`CHP_CFG0_OFS, 32'h5);
    s1 = {24'h001000, 24'h0, 24'h010000};
    dc3({48'hffffffffffff, 24'h0});
    chk(72'(last_out.n > o2.n), 72'h1);
    wr(`CHP_CFG0_OFS, 32'h3);
    dc3({24'h0, 48'hffffffffffff});
    chk(72'(last_out.i > o2.i), 72'h1);
    do_reset();
    wr(`CHP_CFG0_OFS, 32'h1);
    wr(`CHP_IGAIN_OFS, 32'h08000000);
    for (int r = 0; r < 5; r++) begin
      wr(ma(`CHP_LO_BASE + r), 32'(lo[r]));
      wr(ma(`CHP_HI_BASE + r), 32'(hi[r]));
      wr(ma(`CHP_GAIN_BASE + r), 32'(r) << 27);
      wr(ma(`CHP_PHC_BASE + r), r == 2 ? 32'h04000000 : 32'h0);
    end
    repeat (12) @(posedge hclk);
    pair(24'sd2, 1'b0);
    wr(`CHP_CFG0_OFS, 32'h9);
    // region walk with hysteresis and end caps
    for (int j = 0; j < 12; j++) begin
      if (j == 11)
        wr(`CHP_CFG0_OFS, 32'h1);
      rms_req <= 1'b1;
      rms_req_val <= j == 11 ? 500 : rv[j];
      @(posedge hclk);
      rms_req <= 1'b0;
      repeat (12) @(posedge hclk);
      rdc(`CHP_REGION_OFS, j == 11 ? 32'h0 : 32'(rx[j]));
      pair(24'(j == 11 ? 2 : 2 * (1 + rx[j])), j < 11 && rx[j] == 2);
    end
    wr(`CHP_CFG0_OFS, 32'h0);
    repeat (4) @(posedge hclk);
    chk(72'(exp_q.size()), 72'h0);
    results();
  end
endmodule : channel_hpf_integrator_phase_cal_test
